// *** dual_counter_timer.sv ***
// two classic counter/timers with gating and external interrupt flags
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dual_counter_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic ext_count_pin_zero,
  input wire logic ext_count_pin_one,
  input wire logic ext_irq_input_zero,
  input wire logic ext_irq_input_one,
  // vector acknowledges from the interrupt controller
  input wire logic vector_timer_zero,
  input wire logic vector_timer_one,
  input wire logic vector_irq_zero,
  input wire logic vector_irq_one,
  // status outputs
  output logic overflow_flag_zero,
  output logic overflow_flag_one,
  output logic ext_irq_flag_zero,
  output logic ext_irq_flag_one,
  output logic baud_overflow_one
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] mode;
    logic [7:0] tick_div;
    logic [7:0] count_low_zero;
    logic [7:0] count_high_zero;
    logic [7:0] count_low_one;
    logic [7:0] count_high_one;
    logic [3:0] prescale;
    logic irq_last_zero;
    logic irq_last_one;
    logic [7:0] rdata;
    logic baud_pulse;
  } timer_state_type;

  timer_state_type state;
  timer_state_type next_state;
  logic fall_zero;
  logic fall_one;

  // falling edges on the count pins, two samples each
  timer_count_edge edge_zero (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(ext_count_pin_zero),
    .fall(fall_zero)
  );
  timer_count_edge edge_one (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(ext_count_pin_one),
    .fall(fall_one)
  );

  logic tick12;
  logic [1:0] mode_field_zero;
  logic [1:0] mode_field_one;
  logic split;
  logic inc_zero;
  logic inc_one;
  logic inc_high_split;
  logic en_zero;
  logic en_one;
  logic [12:0] sum13;
  logic [16:0] sum16;
  logic [8:0] sum8;
  logic ovf_zero;
  logic ovf_one_raw;
  logic ovf_split_high;
  logic [7:0] low0;
  logic [7:0] high0;
  logic [7:0] low1;
  logic [7:0] high1;
  logic [7:0] ctl;
  logic irq_fall_zero;
  logic irq_fall_one;

  // tick sources and enables
  always_comb begin
    tick12 = (state.prescale == timer_pkg::TICK_DIV_LAST);
    mode_field_zero = state.mode[timer_pkg::MODE_FIELD_ZERO_HI:
                                 timer_pkg::MODE_FIELD_ZERO_LO];
    mode_field_one = state.mode[timer_pkg::MODE_FIELD_ONE_HI:
                                timer_pkg::MODE_FIELD_ONE_LO];
    split = (mode_field_zero == timer_pkg::MODE_SPLIT);
    // run and gate
    en_zero = state.control[timer_pkg::CTL_RUN_ZERO] &
              (~state.mode[timer_pkg::MODE_GATE_ZERO] |
               ext_irq_input_zero);
    en_one = state.control[timer_pkg::CTL_RUN_ONE] &
             (~state.mode[timer_pkg::MODE_GATE_ONE] |
              ext_irq_input_one);
    // source select
    if (state.mode[timer_pkg::MODE_SRC_ZERO]) begin
      inc_zero = en_zero & fall_zero;
    end else begin
      inc_zero = en_zero & (state.tick_div[timer_pkg::TDIV_ZERO] |
                            tick12);
    end
    if (state.mode[timer_pkg::MODE_SRC_ONE] && !split) begin
      inc_one = en_one & fall_one;
    end else begin
      inc_one = en_one & (state.tick_div[timer_pkg::TDIV_ONE] |
                          tick12);
    end
    // split high byte: run one, tick only, no gate
    inc_high_split = state.control[timer_pkg::CTL_RUN_ONE] &
                     (state.tick_div[timer_pkg::TDIV_ZERO] |
                      tick12);
    if (mode_field_one == timer_pkg::MODE_SPLIT) begin
      inc_one = 1'b0;
    end
  end

  // timer zero counting
  always_comb begin
    low0 = state.count_low_zero;
    high0 = state.count_high_zero;
    ovf_zero = 1'b0;
    ovf_split_high = 1'b0;
    sum13 = 13'({state.count_high_zero,
                 state.count_low_zero[4:0]} + 13'h1);
    sum16 = {1'b0, state.count_high_zero, state.count_low_zero} + 17'h1;
    sum8 = {1'b0, state.count_low_zero} + 9'h1;
    case (mode_field_zero)
      timer_pkg::MODE_13BIT: begin
        if (inc_zero) begin
          high0 = sum13[12:5];
          low0 = {state.count_low_zero[7:5], sum13[4:0]};
          ovf_zero = (sum13 == 13'h0);
        end
      end
      timer_pkg::MODE_16BIT: begin
        if (inc_zero) begin
          {high0, low0} = sum16[15:0];
          ovf_zero = sum16[16];
        end
      end
      timer_pkg::MODE_RELOAD: begin
        if (inc_zero) begin
          ovf_zero = sum8[8];
          low0 = sum8[8] ? state.count_high_zero : sum8[7:0];
        end
      end
      timer_pkg::MODE_SPLIT: begin
        if (inc_zero) begin
          low0 = sum8[7:0];
          ovf_zero = sum8[8];
        end
        if (inc_high_split) begin
          high0 = 8'(state.count_high_zero + 8'h01);
          ovf_split_high = (state.count_high_zero == timer_pkg::BYTE_ONES);
        end
      end
      default: begin
        ovf_zero = 1'b0;
      end
    endcase
  end

  // timer one counting, modes 0 to 2 as timer zero; mode 3 holds
  always_comb begin
    logic [12:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = 13'({state.count_high_one, state.count_low_one[4:0]} + 13'h1);
    s16 = {1'b0, state.count_high_one, state.count_low_one} + 17'h1;
    s8 = {1'b0, state.count_low_one} + 9'h1;
    low1 = state.count_low_one;
    high1 = state.count_high_one;
    ovf_one_raw = 1'b0;
    if (inc_one) begin
      case (mode_field_one)
        timer_pkg::MODE_13BIT: begin
          high1 = s13[12:5];
          low1 = {state.count_low_one[7:5], s13[4:0]};
          ovf_one_raw = (s13 == 13'h0);
        end
        timer_pkg::MODE_16BIT: begin
          {high1, low1} = s16[15:0];
          ovf_one_raw = s16[16];
        end
        timer_pkg::MODE_RELOAD: begin
          ovf_one_raw = s8[8];
          low1 = s8[8] ? state.count_high_one : s8[7:0];
        end
        default: begin
          ovf_one_raw = 1'b0;
        end
      endcase
    end
  end

  // external interrupt edge detection
  assign irq_fall_zero = state.irq_last_zero & ~ext_irq_input_zero;
  assign irq_fall_one = state.irq_last_one & ~ext_irq_input_one;

  // next state: register writes, flags, reads
  always_comb begin
    next_state = state;
    next_state.prescale = tick12 ? 4'h0 : 4'(state.prescale + 4'h1);
    next_state.irq_last_zero = ext_irq_input_zero;
    next_state.irq_last_one = ext_irq_input_one;
    next_state.count_low_zero = low0;
    next_state.count_high_zero = high0;
    next_state.count_low_one = low1;
    next_state.count_high_one = high1;
    next_state.baud_pulse = ovf_one_raw;
    ctl = state.control;
    if (reg_write) begin
      case (reg_addr)
        timer_pkg::ADDR_CONTROL: ctl = reg_wdata;
        timer_pkg::ADDR_MODE: next_state.mode = reg_wdata;
        timer_pkg::ADDR_TICK_DIV: begin
          next_state.tick_div = reg_wdata & timer_pkg::TDIV_MASK;
        end
        timer_pkg::ADDR_COUNT_LOW_ZERO: next_state.count_low_zero = reg_wdata;
        timer_pkg::ADDR_COUNT_HIGH_ZERO: begin
          next_state.count_high_zero = reg_wdata;
        end
        timer_pkg::ADDR_COUNT_LOW_ONE: next_state.count_low_one = reg_wdata;
        timer_pkg::ADDR_COUNT_HIGH_ONE: next_state.count_high_one = reg_wdata;
        default: ctl = state.control;
      endcase
    end
    // vectoring clears overflow and edge flags
    if (vector_timer_zero) ctl[timer_pkg::CTL_OVF_ZERO] = 1'b0;
    if (vector_timer_one) ctl[timer_pkg::CTL_OVF_ONE] = 1'b0;
    if (vector_irq_zero && ctl[timer_pkg::CTL_IRQ_TYPE_ZERO]) begin
      ctl[timer_pkg::CTL_IRQ_FLAG_ZERO] = 1'b0;
    end
    if (vector_irq_one && ctl[timer_pkg::CTL_IRQ_TYPE_ONE]) begin
      ctl[timer_pkg::CTL_IRQ_FLAG_ONE] = 1'b0;
    end
    // hardware sets win over clears
    if (ovf_zero) ctl[timer_pkg::CTL_OVF_ZERO] = 1'b1;
    if (ovf_split_high || (ovf_one_raw && !split)) begin
      ctl[timer_pkg::CTL_OVF_ONE] = 1'b1;
    end
    if (ctl[timer_pkg::CTL_IRQ_TYPE_ZERO]) begin
      if (irq_fall_zero) ctl[timer_pkg::CTL_IRQ_FLAG_ZERO] = 1'b1;
    end else begin
      ctl[timer_pkg::CTL_IRQ_FLAG_ZERO] = ~ext_irq_input_zero;
    end
    if (ctl[timer_pkg::CTL_IRQ_TYPE_ONE]) begin
      if (irq_fall_one) ctl[timer_pkg::CTL_IRQ_FLAG_ONE] = 1'b1;
    end else begin
      ctl[timer_pkg::CTL_IRQ_FLAG_ONE] = ~ext_irq_input_one;
    end
    next_state.control = ctl;
    // read data, one cycle later
    next_state.rdata = timer_pkg::RESET_BYTE;
    if (reg_read) begin
      case (reg_addr)
        timer_pkg::ADDR_CONTROL: next_state.rdata = state.control;
        timer_pkg::ADDR_MODE: next_state.rdata = state.mode;
        timer_pkg::ADDR_TICK_DIV: begin
          next_state.rdata = state.tick_div & timer_pkg::TDIV_MASK;
        end
        timer_pkg::ADDR_COUNT_LOW_ZERO: begin
          next_state.rdata = state.count_low_zero;
        end
        timer_pkg::ADDR_COUNT_HIGH_ZERO: begin
          next_state.rdata = state.count_high_zero;
        end
        timer_pkg::ADDR_COUNT_LOW_ONE: next_state.rdata = state.count_low_one;
        timer_pkg::ADDR_COUNT_HIGH_ONE: begin
          next_state.rdata = state.count_high_one;
        end
        default: next_state.rdata = timer_pkg::RESET_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.irq_last_zero <= 1'b1;
      state.irq_last_one <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = state.rdata;
  assign overflow_flag_zero = state.control[timer_pkg::CTL_OVF_ZERO];
  assign overflow_flag_one = state.control[timer_pkg::CTL_OVF_ONE];
  assign ext_irq_flag_zero = state.control[timer_pkg::CTL_IRQ_FLAG_ZERO];
  assign ext_irq_flag_one = state.control[timer_pkg::CTL_IRQ_FLAG_ONE];
  assign baud_overflow_one = state.baud_pulse;
endmodule
`default_nettype wire

// *** timer_pkg.sv ***
// shared constants for the dual counter/timer block
package timer_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_COUNT_LOW_ZERO = 8'h8A;
  localparam logic [7:0] ADDR_COUNT_LOW_ONE = 8'h8B;
  localparam logic [7:0] ADDR_COUNT_HIGH_ZERO = 8'h8C;
  localparam logic [7:0] ADDR_COUNT_HIGH_ONE = 8'h8D;
  localparam logic [7:0] ADDR_TICK_DIV = 8'h8E;
  // control register fields
  localparam int CTL_OVF_ONE = 7;
  localparam int CTL_RUN_ONE = 6;
  localparam int CTL_OVF_ZERO = 5;
  localparam int CTL_RUN_ZERO = 4;
  localparam int CTL_IRQ_FLAG_ONE = 3;
  localparam int CTL_IRQ_TYPE_ONE = 2;
  localparam int CTL_IRQ_FLAG_ZERO = 1;
  localparam int CTL_IRQ_TYPE_ZERO = 0;
  // mode register fields
  localparam int MODE_GATE_ONE = 7;
  localparam int MODE_SRC_ONE = 6;
  localparam int MODE_FIELD_ONE_HI = 5;
  localparam int MODE_FIELD_ONE_LO = 4;
  localparam int MODE_GATE_ZERO = 3;
  localparam int MODE_SRC_ZERO = 2;
  localparam int MODE_FIELD_ZERO_HI = 1;
  localparam int MODE_FIELD_ZERO_LO = 0;
  // tick divider select fields and writable mask
  localparam int TDIV_FOUR = 6;
  localparam int TDIV_TWO = 5;
  localparam int TDIV_ONE = 4;
  localparam int TDIV_ZERO = 3;
  localparam logic [7:0] TDIV_MASK = 8'h78;
  // mode encodings
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // 13-bit low-byte mask and tick divide
  localparam logic [7:0] LOW5_MASK = 8'h1F;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam int SYS_CLK_MHZ = 100;
  localparam int TICK_DIVIDE = 12;
  localparam logic [3:0] TICK_DIV_LAST = 4'(TICK_DIVIDE - 1);
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// *** timer_count_edge.sv ***
// falling-edge detector for one external count pin
`timescale 1ns/1ps
`default_nettype none
module timer_count_edge (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // pin and result
  input wire logic pin,
  output logic fall
);
  typedef struct packed {
    logic sample;
    logic last;
  } edge_state_type;

  edge_state_type state;
  edge_state_type next_state;

  // pin is synchronous: sample then compare with the previous sample
  always_comb begin
    next_state = state;
    next_state.sample = pin;
    next_state.last = state.sample;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{sample: 1'b1, last: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign fall = state.last & ~state.sample;
endmodule
`default_nettype wire

// *** timer_checks_properties.sv ***
// port-level assertion checker for the dual counter/timer
`timescale 1ns/1ps
`default_nettype none
module timer_checks (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // pins and acknowledges
  input wire logic ext_irq_input_zero,
  input wire logic ext_irq_input_one,
  input wire logic vector_timer_zero,
  input wire logic vector_timer_one,
  input wire logic vector_irq_one,
  // status
  input wire logic overflow_flag_zero,
  input wire logic overflow_flag_one,
  input wire logic ext_irq_flag_zero,
  input wire logic ext_irq_flag_one,
  input wire logic baud_overflow_one
);
  logic [7:0] mode_sh;
  logic [7:0] ctl_sh;
  logic ctl_wr;
  logic clr0;
  logic clr1;
  logic t1_flags;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // decoded writes and flag clear causes
  assign ctl_wr = reg_write && reg_addr == 8'h88;
  assign clr0 = vector_timer_zero || ctl_wr && !reg_wdata[5];
  assign clr1 = vector_timer_one || ctl_wr && !reg_wdata[7];
  assign t1_flags = mode_sh[1:0] != 2'h3 && mode_sh[5:4] != 2'h3 && !ctl_wr;
  // shadow copies of mode and control writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_sh <= 8'h00;
      ctl_sh <= 8'h00;
    end else if (reg_write && reg_addr == 8'h89) begin
      mode_sh <= reg_wdata;
    end else if (ctl_wr) begin
      ctl_sh <= reg_wdata;
    end
  end
  AST_TDIV_RSVD: assert property (
    reg_read && reg_addr == 8'h8E |=> (reg_rdata & 8'h87) == 8'h00)
    else $error("reserved divider bits read nonzero");
  AST_OVF0_CLEAR: assert property (
    $fell(overflow_flag_zero) |-> $past(clr0) || $past(clr0, 2))
    else $error("timer zero flag dropped without a clear");
  AST_OVF1_CLEAR: assert property (
    $fell(overflow_flag_one) |-> $past(clr1) || $past(clr1, 2))
    else $error("timer one flag dropped without a clear");
  AST_BAUD_FLAG: assert property (
    t1_flags [*3] ##0 baud_overflow_one |-> ##[0:2] overflow_flag_one)
    else $error("timer one overflow left its flag clear");
  AST_MODE3_HOLD: assert property (
    (mode_sh[5:4] == 2'h3) [*4] |-> !baud_overflow_one)
    else $error("timer one overflowed while inactive");
  AST_LEVEL_FLAG0: assert property (
    (!ctl_sh[0] && !ctl_wr && $stable(ext_irq_input_zero)) [*5]
      |-> ext_irq_flag_zero == !ext_irq_input_zero)
    else $error("level flag is not the inverted input");
  AST_EDGE_SET1: assert property (
    ctl_sh[2] && !ctl_wr && $fell(ext_irq_input_one)
      |-> ##[1:5] ext_irq_flag_one)
    else $error("falling edge did not set the edge flag");
  AST_EDGE_CLR1: assert property (
    (ctl_sh[2] && !ctl_wr && ext_irq_input_one) [*6] ##0 vector_irq_one
      |-> ##[1:3] !ext_irq_flag_one)
    else $error("vector did not clear the edge flag");
  // main scenarios reached
  cover property (baud_overflow_one);
  cover property ($rose(overflow_flag_zero));
  cover property ($rose(ext_irq_flag_one));
endmodule
bind dual_counter_timer timer_checks u_chk (
  .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .ext_irq_input_zero, .ext_irq_input_one,
  .vector_timer_zero, .vector_timer_one, .vector_irq_one,
  .overflow_flag_zero, .overflow_flag_one, .ext_irq_flag_zero,
  .ext_irq_flag_one, .baud_overflow_one
);
`default_nettype wire

// *** pin_source.sv ***
// behavioural source of falling edges on one external count pin
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
  parameter int EDGES = 7
) (
  // clock
  input wire logic core_clk,
  // request
  input wire logic start,
  input wire logic [1:0] hold,
  // pin and status
  output logic pin,
  output logic busy
);
  int left = 0;
  int cnt = 0;
  initial pin = 1'b1;
  initial busy = 1'b0;
  // each level stands hold cycles, never fewer than two
  always @(posedge core_clk) begin
    if (start && !busy) begin
      left <= 2 * EDGES;
      cnt <= (hold < 2'h2) ? 2 : int'(hold);
      busy <= 1'b1;
    end else if (busy && cnt > 1) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      pin <= ~pin;
      cnt <= (hold < 2'h2) ? 2 : int'(hold);
      left <= left - 1;
      busy <= left > 1;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the dual counter/timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {string name; logic [7:0] exp; logic [7:0] mask;} note_type;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_count_pin_zero, ext_count_pin_one;
  logic ext_irq_input_zero = 1'b1;
  logic ext_irq_input_one = 1'b1;
  logic vector_timer_zero = 1'b0;
  logic vector_timer_one = 1'b0;
  logic vector_irq_zero = 1'b0;
  logic vector_irq_one = 1'b0;
  logic overflow_flag_zero, overflow_flag_one, baud_overflow_one;
  logic ext_irq_flag_zero, ext_irq_flag_one;
  logic start = 1'b0;
  logic [1:0] hold = 2'h2;
  logic busy0;
  logic rd_seen = 1'b0;
  logic [7:0] r;
  note_type nt;
  note_type notes[$];
  int bad_count = 0;
  int n_checks = 0;
  int n_baud = 0;
  int seed = 57334;
  logic [7:0] ovf_pair;
  // both overflow flags in one byte for the flag checks
  assign ovf_pair = {6'h00, overflow_flag_one, overflow_flag_zero};
  dual_counter_timer u_dut (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .ext_count_pin_zero, .ext_count_pin_one,
    .ext_irq_input_zero, .ext_irq_input_one, .vector_timer_zero,
    .vector_timer_one, .vector_irq_zero, .vector_irq_one,
    .overflow_flag_zero, .overflow_flag_one, .ext_irq_flag_zero,
    .ext_irq_flag_one, .baud_overflow_one
  );
  pin_source u_pin0 (.core_clk, .start, .hold, .pin(ext_count_pin_zero),
    .busy(busy0));
  pin_source u_pin1 (.core_clk, .start, .hold, .pin(ext_count_pin_one),
    .busy());
  initial forever #5 core_clk = ~core_clk;
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(logic w, logic rd, logic [7:0] a, logic [7:0] d);
    reg_write <= w;
    reg_read <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic idle(int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic rd(string s, logic [7:0] a, logic [7:0] e, logic [7:0] m);
    notes.push_back('{s, e, m});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic setup(logic [7:0] m, logic [7:0] td, logic t,
                       logic [7:0] lo, logic [7:0] hi);
    bus(1'b1, 1'b0, 8'h89, m);
    bus(1'b1, 1'b0, 8'h8E, td);
    bus(1'b1, 1'b0, 8'h8A + t, lo);
    bus(1'b1, 1'b0, 8'h8C + t, hi);
  endtask
  task automatic cnt(logic t, logic [7:0] lo, logic [7:0] hi, logic [7:0] m);
    rd("count low", 8'h8A + t, lo, m);
    rd("count high", 8'h8C + t, hi, 8'hFF);
  endtask
  // run exactly k cycles, keep flags, then clear them by vector
  task automatic run(logic [7:0] v, int k, logic [1:0] f);
    bus(1'b1, 1'b0, 8'h88, v);
    idle(k - 1);
    check("flags", ovf_pair, 8'(f));
    bus(1'b1, 1'b0, 8'h88, {f[1], 1'b0, f[0], 5'h00});
    vector_timer_zero <= 1'b1;
    vector_timer_one <= 1'b1;
    idle(1);
    vector_timer_zero <= 1'b0;
    vector_timer_one <= 1'b0;
    idle(2);
    check("vectored", ovf_pair, 8'h00);
  endtask
  // read data stand in the cycle after the read strobe
  always @(posedge core_clk) begin
    if (rd_seen) begin
      nt = notes.pop_front();
      check(nt.name, reg_rdata & nt.mask, nt.exp & nt.mask);
    end
    rd_seen <= reg_read;
    if (baud_overflow_one === 1'b1) n_baud++;
  end
  initial begin
    #100000;
    bad_count++;
    $display("[FAIL] run exp done seen hang");
    end_sim;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    idle(1);
    rd("control", 8'h88, 8'h00, 8'hFF);
    rd("mode", 8'h89, 8'h00, 8'hFF);
    bus(1'b1, 1'b0, 8'h8E, 8'hF8); // reserved bit 7 written one, reads back zero
    rd("divider", 8'h8E, 8'h78, 8'hFF);
    rd("unmapped", 8'h87, 8'h00, 8'hFF);
    $display("test registers done");
    setup(8'h01, 8'h08, 1'b0, 8'hFE, 8'hFF);
    run(8'h10, 6, 2'b01);
    cnt(1'b0, 8'h04, 8'h00, 8'hFF);
    setup(8'h00, 8'h08, 1'b0, 8'hDE, 8'hFF);
    run(8'h10, 6, 2'b01);
    cnt(1'b0, 8'h04, 8'h00, 8'h1F);
    setup(8'h02, 8'h08, 1'b0, 8'hFE, 8'hF0);
    run(8'h10, 6, 2'b01);
    cnt(1'b0, 8'hF4, 8'hF0, 8'hFF);
    setup(8'h01, 8'h10, 1'b0, 8'h00, 8'h00);
    run(8'h10, 48, 2'b00);
    cnt(1'b0, 8'h04, 8'h00, 8'hFF);
    $display("test modes done");
    r = 8'($random(seed)) & 8'h7F;
    setup(8'h09, 8'h08, 1'b0, r, 8'h00);
    ext_irq_input_zero <= 1'b0;
    idle(6);
    check("level flag", {7'h00, ext_irq_flag_zero}, 8'h01);
    run(8'h10, 6, 2'b00);
    ext_irq_input_zero <= 1'b1;
    idle(6);
    run(8'h10, 6, 2'b00);
    cnt(1'b0, r + 8'h06, 8'h00, 8'hFF);
    $display("test gate done");
    setup(8'h05, 8'h08, 1'b0, 8'h00, 8'h00);
    bus(1'b1, 1'b0, 8'h88, 8'h10);
    for (int h = 2; h < 4; h++) begin
      hold <= 2'(h);
      start <= 1'b1;
      idle(1);
      start <= 1'b0;
      for (int i = 0; i < 300 && (i < 2 || busy0); i++) idle(1);
      if (busy0) begin
        bad_count++;
        $display("[FAIL] pins exp idle seen busy");
        end_sim;
      end
    end
    idle(4);
    bus(1'b1, 1'b0, 8'h88, 8'h00);
    cnt(1'b0, 8'h0E, 8'h00, 8'hFF);
    $display("test counter done");
    setup(8'h10, 8'h10, 1'b1, 8'hFE, 8'hFF);
    run(8'h40, 6, 2'b10);
    check("baud", 8'(n_baud), 8'h01);
    bus(1'b1, 1'b0, 8'h89, 8'h30);
    run(8'h40, 6, 2'b00);
    cnt(1'b1, 8'h04, 8'h00, 8'hFF);
    setup(8'h33, 8'h08, 1'b0, 8'h55, 8'hFE);
    run(8'h40, 6, 2'b10);
    cnt(1'b0, 8'h55, 8'h04, 8'hFF);
    bus(1'b1, 1'b0, 8'h88, 8'hA0);
    bus(1'b1, 1'b0, 8'h88, 8'h00);
    idle(3);
    check("sw clear", ovf_pair, 8'h00);
    // split timer zero: timer one leaves mode 3, counts ticks, no flag
    setup(8'h53, 8'h10, 1'b1, 8'hFE, 8'hFF);
    run(8'h40, 6, 2'b00);
    check("split baud", 8'(n_baud), 8'h02);
    cnt(1'b1, 8'h04, 8'h00, 8'hFF);
    $display("test timer one done");
    bus(1'b1, 1'b0, 8'h88, 8'h05);
    ext_irq_input_zero <= 1'b0;
    ext_irq_input_one <= 1'b0;
    idle(6);
    check("edge flags", {6'h00, ext_irq_flag_one, ext_irq_flag_zero},
          8'h03);
    ext_irq_input_zero <= 1'b1;
    ext_irq_input_one <= 1'b1;
    idle(7);
    vector_irq_zero <= 1'b1;
    vector_irq_one <= 1'b1;
    idle(1);
    vector_irq_zero <= 1'b0;
    vector_irq_one <= 1'b0;
    idle(4);
    check("edge flags", {6'h00, ext_irq_flag_one, ext_irq_flag_zero},
          8'h00);
    $display("test interrupt flags done");
    idle(3);
    end_sim;
  end
endmodule
`default_nettype wire
